// *** flash_bus_cycle.sv ***
// one write or read cycle on the parallel flash pins
`timescale 1ns/1ps
`default_nettype none
module flash_bus_cycle
  import flash_erase_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic is_write,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] dq_in,
  output logic done,
  output logic [7:0] rdata,
  output logic ce_n,
  output logic we_n,
  output logic oe_n,
  output logic [ADDR_W-1:0] addr_out,
  output logic [7:0] dq_out,
  output logic dq_oe
);
  typedef struct packed {
    bus_op_t op;
    logic [2:0] cnt;
    logic done;
    logic [7:0] rdata;
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic [ADDR_W-1:0] addr;
    logic [7:0] dq;
    logic dq_oe;
    logic [7:0] s1;
    logic [7:0] s2;
  } bus_state_t;
  bus_state_t cur_reg, cur_next;
  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    cur_next = cur_reg;
    cur_next.done = 1'b0;
    cur_next.s1 = dq_in;
    cur_next.s2 = cur_reg.s1;
    unique case (cur_reg.op)
      BUS_IDLE: begin
        if (start) begin
          cur_next.op = is_write ? BUS_WRITE : BUS_READ;
          cur_next.cnt = 3'h0;
          cur_next.addr = addr;
          cur_next.dq = wdata;
          cur_next.ce_n = 1'b0;
          // oe held high through writes so the strobes are legal
          cur_next.we_n = !is_write;
          cur_next.oe_n = is_write;
          cur_next.dq_oe = is_write;
        end
      end
      default: begin
        cur_next.cnt = cur_reg.cnt + 3'h1;
        // extra cycles let read data pass the two-stage sync
        if (cur_reg.cnt == 3'(STROBE_CYC + 2)) begin
          cur_next.op = BUS_IDLE;
          cur_next.done = 1'b1;
          cur_next.rdata = cur_reg.s2;
          cur_next.ce_n = 1'b1;
          cur_next.oe_n = 1'b1;
          cur_next.dq_oe = 1'b0;
        end
        if (cur_reg.cnt == 3'(STROBE_CYC)) begin
          cur_next.we_n = 1'b1;
        end
      end
    endcase
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_reg <= '{op: BUS_IDLE, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                   default: '0};
    end else begin
      cur_reg <= cur_next;
    end
  end
  assign done = cur_reg.done;
  assign rdata = cur_reg.rdata;
  assign ce_n = cur_reg.ce_n;
  assign we_n = cur_reg.we_n;
  assign oe_n = cur_reg.oe_n;
  assign addr_out = cur_reg.addr;
  assign dq_out = cur_reg.dq;
  assign dq_oe = cur_reg.dq_oe;
  ////////////////////////////////////////////////////////////////////////////
  property p_write_strobes;
    @(posedge sys_clk) disable iff (!rst_n)
    !we_n |-> (!ce_n && oe_n);
  endproperty
  a_write_strobes: assert property (p_write_strobes)
    else $error("write strobe with illegal enables");
  property p_read_quiet;
    @(posedge sys_clk) disable iff (!rst_n)
    !oe_n |-> (we_n && !ce_n && !dq_oe);
  endproperty
  a_read_quiet: assert property (p_read_quiet)
    else $error("read strobe overlaps a write or drive");
endmodule : flash_bus_cycle
`default_nettype wire

// *** flash_dev_model.sv ***
// behavioural model of the byte-wide bulk-erase flash device
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model
  import flash_erase_pkg::*;
#(
  parameter int ACC_NS = 70
)(
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] dq_in,
  input wire logic program_supply,
  output logic [7:0] dq
);
  logic [7:0] mem [0:(1<<ADDR_W)-1];
  logic [7:0] cmd;
  logic [7:0] last;
  logic [7:0] pd;
  logic [7:0] rd_val;
  logic [ADDR_W-1:0] wr_addr;
  logic [ADDR_W-1:0] pa;
  logic [ADDR_W-1:0] ea;
  logic erasing;
  logic programming;
  logic [ADDR_W-1:0] weak_addr;
  int weak_left;
  initial begin
    weak_addr = '0;
    weak_left = 0;
    foreach (mem[i]) mem[i] = DATA_ERASED;
    cmd = CMD_READ;
    erasing = 1'b0;
    programming = 1'b0;
    last = 8'h00;
    pa = '0;
    ea = '0;
    wr_addr = '0;
  end
  ////////////////////////////////////////////////////////////////////////
  // address taken on the later of the two falling strobes
  always @(negedge we_n or negedge ce_n) begin
    // both strobes and the address settle within one time step
    #1;
    if (!we_n && !ce_n && oe_n) wr_addr = addr;
  end
  // no supply: register pinned to read, array read-only
  always @(program_supply) begin
    if (!program_supply) cmd = CMD_READ;
  end
  // a write counts only with proper strobes and supply present
  always @(posedge we_n) begin
    if (!ce_n && oe_n && program_supply) begin
      if (cmd == CMD_PROG_SETUP) begin
        pa = wr_addr;
        pd = dq_in;
        programming = 1'b1;
        cmd = 8'h01;
      end else if (cmd == CMD_ERASE && dq_in == CMD_ERASE) begin
        erasing = 1'b1;
        cmd = 8'h02;
      end else begin
        // stop timer caps a pulse, so its length adds nothing
        if (erasing) foreach (mem[i]) mem[i] = DATA_ERASED;
        // a weak cell stays charged for a set number of pulses
        if (erasing && weak_left > 0) begin
          mem[weak_addr] = 8'h7F;
          weak_left--;
        end
        if (programming) mem[pa] = mem[pa] & pd;
        erasing = 1'b0;
        programming = 1'b0;
        if (dq_in == CMD_ERASE_VERIFY) ea = wr_addr;
        cmd = dq_in;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  always @* begin
    if (cmd == CMD_ERASE_VERIFY) rd_val = mem[ea];
    else if (cmd == CMD_PROG_VERIFY) rd_val = mem[pa];
    else rd_val = mem[addr];
  end
  always @(posedge oe_n) last = rd_val;
  // no pull-up on the data lines: released bus shows stale inverse
  assign #(ACC_NS) dq = (!ce_n && !oe_n) ? rd_val : ~last;
endmodule : flash_dev_model
`default_nettype wire

// *** flash_erase_host.sv ***
// host sequencer: zero-fill, bulk erase with verify, then program setup
`timescale 1ns/1ps
`default_nettype none
module flash_erase_host
  import flash_erase_pkg::*;
#(
  parameter int ERASE_WAIT = ERASE_CYC,
  parameter logic [ADDR_W-1:0] LAST_ADDR = ADDR_LAST
)(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [7:0] dq_in,
  output logic busy,
  output logic erase_ok,
  output logic erase_fail,
  output logic [9:0] pulses,
  output logic [ADDR_W-1:0] fail_addr,
  output logic ce_n,
  output logic we_n,
  output logic oe_n,
  output logic [ADDR_W-1:0] addr,
  output logic [7:0] dq_out,
  output logic dq_oe,
  output logic program_supply
);
  typedef struct packed {
    seq_state_t st;
    logic [ADDR_W-1:0] addr;
    logic [9:0] erase_pulse_counter;
    logic [CNT_W-1:0] tmr;
    logic all_ff;
    logic start;
    logic is_write;
    logic [7:0] wdata;
    logic ok;
    logic fail;
    logic supply;
  } host_state_t;
  host_state_t cur_reg, cur_next;
  logic bus_done;
  logic [7:0] bus_rdata;
  logic go_s1, go_s2;

  flash_bus_cycle u_bus (
    .sys_clk(sys_clk), .rst_n(rst_n), .start(cur_reg.start),
    .is_write(cur_reg.is_write), .addr(cur_reg.addr),
    .wdata(cur_reg.wdata), .dq_in(dq_in), .done(bus_done),
    .rdata(bus_rdata), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
    .addr_out(addr), .dq_out(dq_out), .dq_oe(dq_oe)
  );
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      go_s1 <= 1'b0;
      go_s2 <= 1'b0;
    end else begin
      go_s1 <= go;
      go_s2 <= go_s1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic host_state_t issue(host_state_t s, logic wr,
                                         logic [7:0] d, seq_state_t nx);
    host_state_t r;
    r = s;
    r.start = 1'b1;
    r.is_write = wr;
    r.wdata = d;
    r.st = nx;
    return r;
  endfunction : issue

  always_comb begin
    cur_next = cur_reg;
    cur_next.start = 1'b0;
    if (cur_reg.tmr != '0) begin
      cur_next.tmr = cur_reg.tmr - CNT_W'(1);
    end
    unique case (cur_reg.st)
      ST_IDLE: begin
        if (go_s2) begin
          cur_next.supply = 1'b1;
          cur_next.ok = 1'b0;
          cur_next.fail = 1'b0;
          cur_next.all_ff = 1'b1;
          cur_next.addr = ADDR_FIRST;
          cur_next.erase_pulse_counter = '0;
          cur_next = issue(cur_next, 1'b0, DATA_ZERO, ST_SCAN_RD);
        end
      end
      ST_SCAN_RD: if (bus_done) begin
        cur_next.st = ST_SCAN_CHK;
        if (bus_rdata != DATA_ERASED) cur_next.all_ff = 1'b0;
      end
      ST_SCAN_CHK: begin
        if (cur_reg.addr == LAST_ADDR) begin
          cur_next.addr = ADDR_FIRST;
          // blank part skips erase and goes to programming
          cur_next.st = cur_reg.all_ff ? ST_PROG_SETUP : ST_ZERO_SETUP;
          if (cur_reg.all_ff) cur_next.ok = 1'b1;
        end else begin
          cur_next.addr = cur_reg.addr + ADDR_W'(1);
          cur_next = issue(cur_next, 1'b0, DATA_ZERO, ST_SCAN_RD);
        end
      end
      ST_ZERO_SETUP: cur_next = issue(cur_next, 1'b1, CMD_PROG_SETUP,
                                      ST_ZERO_WR);
      ST_ZERO_WR: if (bus_done) begin
        cur_next = issue(cur_next, 1'b1, DATA_ZERO, ST_ZERO_WAIT);
      end
      ST_ZERO_WAIT: if (bus_done) begin
        cur_next.tmr = CNT_W'(PROG_CYC);
        cur_next.st = ST_ZERO_VER;
      end
      ST_ZERO_VER: if (cur_reg.tmr == '0) begin
        cur_next = issue(cur_next, 1'b1, CMD_PROG_VERIFY,
                         ST_ZERO_REC);
      end
      ST_ZERO_REC: if (bus_done) begin
        cur_next.tmr = CNT_W'(RECOVER_CYC);
        cur_next.st = ST_ZERO_RD;
      end
      ST_ZERO_RD: if (cur_reg.tmr == '0) begin
        // one read only: a repeated start would slip into the next cycle
        cur_next = issue(cur_next, 1'b0, DATA_ZERO, ST_ZERO_CHK);
      end
      ST_ZERO_CHK: if (bus_done) begin
        // simple zero-fill: retry byte until it reads 00h
        if (bus_rdata != DATA_ZERO) begin
          cur_next.st = ST_ZERO_SETUP;
        end else if (cur_reg.addr == LAST_ADDR) begin
          cur_next.addr = ADDR_FIRST;
          cur_next.st = ST_ER_SETUP;
        end else begin
          cur_next.addr = cur_reg.addr + ADDR_W'(1);
          cur_next.st = ST_ZERO_SETUP;
        end
      end
      ST_ER_SETUP: cur_next = issue(cur_next, 1'b1, CMD_ERASE,
                                    ST_ER_GO);
      ST_ER_GO: if (bus_done) begin
        cur_next = issue(cur_next, 1'b1, CMD_ERASE, ST_ER_WAIT);
      end
      ST_ER_WAIT: if (bus_done) begin
        cur_next.tmr = CNT_W'(ERASE_WAIT);
        cur_next.st = ST_EV_WR;
      end
      ST_EV_WR: if (cur_reg.tmr == '0 && !cur_reg.start) begin
        cur_next = issue(cur_next, 1'b1, CMD_ERASE_VERIFY,
                         ST_EV_REC);
      end
      ST_EV_REC: if (bus_done) begin
        cur_next.tmr = CNT_W'(RECOVER_CYC);
        cur_next.st = ST_EV_RD;
      end
      ST_EV_RD: begin
        if (cur_reg.tmr == '0 && !cur_reg.start) begin
          cur_next = issue(cur_next, 1'b0, DATA_ZERO, ST_EV_CHK);
        end
      end
      ST_EV_CHK: if (bus_done) begin
        if (bus_rdata == DATA_ERASED) begin
          if (cur_reg.addr == LAST_ADDR) begin
            cur_next.ok = 1'b1;
            cur_next.st = ST_PROG_SETUP;
          end else begin
            cur_next.addr = cur_reg.addr + ADDR_W'(1);
            cur_next.st = ST_EV_WR;
          end
        end else begin
          // count the compare; addr kept so verify resumes there
          cur_next.erase_pulse_counter =
            cur_reg.erase_pulse_counter + 10'h001;
          if (cur_reg.erase_pulse_counter + 10'h001 >= PULSE_LIMIT) begin
            // no bus cycle pending here, so the reset write starts now
            cur_next = issue(cur_next, 1'b1, CMD_RESET, ST_DONE);
            cur_next.fail = 1'b1;
          end else begin
            cur_next.st = ST_ER_SETUP;
          end
        end
      end
      ST_PROG_SETUP: cur_next = issue(cur_next, 1'b1, CMD_PROG_SETUP,
                                      ST_RESET_WR);
      ST_RESET_WR: if (bus_done) begin
        cur_next = issue(cur_next, 1'b1, CMD_RESET, ST_DONE);
      end
      ST_DONE: if (bus_done) begin
        cur_next.supply = 1'b0;
        cur_next.st = cur_reg.fail ? ST_FAIL : ST_IDLE;
      end
      ST_FAIL: cur_next.st = ST_IDLE;
      default: cur_next.st = ST_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_reg <= '{st: ST_IDLE, default: '0};
    end else begin
      cur_reg <= cur_next;
    end
  end
  assign busy = (cur_reg.st != ST_IDLE);
  assign erase_ok = cur_reg.ok;
  assign erase_fail = cur_reg.fail;
  assign pulses = cur_reg.erase_pulse_counter;
  assign fail_addr = cur_reg.addr;
  assign program_supply = cur_reg.supply;
  ////////////////////////////////////////////////////////////////////////////
  sequence s_erase_go;
    cur_reg.st == ST_ER_WAIT && bus_done;
  endsequence
  property p_erase_wait;
    @(posedge sys_clk) disable iff (!rst_n)
    s_erase_go |=> cur_reg.tmr == CNT_W'(ERASE_WAIT);
  endproperty
  a_erase_wait: assert property (p_erase_wait)
    else $error("erase interval not loaded");
  property p_recover;
    @(posedge sys_clk) disable iff (!rst_n)
    (cur_reg.st == ST_EV_REC && bus_done) |=>
      cur_reg.tmr == CNT_W'(RECOVER_CYC);
  endproperty
  a_recover: assert property (p_recover)
    else $error("recovery wait not loaded");
  property p_limit;
    @(posedge sys_clk) disable iff (!rst_n)
    cur_reg.erase_pulse_counter <= PULSE_LIMIT;
  endproperty
  a_limit: assert property (p_limit)
    else $error("pulse counter beyond limit");
  property p_fail_stop;
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(cur_reg.fail) |-> (cur_reg.st == ST_DONE && cur_reg.start);
  endproperty
  a_fail_stop: assert property (p_fail_stop)
    else $error("failure did not stop sequence");
  sequence s_verify_miss;
    cur_reg.st == ST_EV_CHK && bus_done && bus_rdata != DATA_ERASED &&
      cur_reg.erase_pulse_counter + 10'h001 < PULSE_LIMIT;
  endsequence
  property p_retry_same;
    @(posedge sys_clk) disable iff (!rst_n)
    s_verify_miss |=> (cur_reg.st == ST_ER_SETUP && $stable(cur_reg.addr));
  endproperty
  a_retry_same: assert property (p_retry_same)
    else $error("failed byte not retried after erase");
endmodule : flash_erase_host
`default_nettype wire

// *** flash_erase_pkg.sv ***
// constants and types for the bulk erase host sequencer
// Notes on behaviour
// - verify bytes one by one, stop on non-FFh byte or all passed.
// - on failed byte, erase chip again and resume at failing address.
// - after all bytes verify, end verify mode with another valid command.
// - program every byte to 00h before any bulk erase.
// - erase verification starts at address 0000h and steps upward.
// - keep pulse counter, increment each compare, never exceed 1000 pulses; the counter here counts failed compares only.
// - read array first; if all FFh, skip erase and go program.
// - erase is two consecutive 20h writes; first is setup only.
// - time 10 ms from erase write's rising write-enable edge.
// - after erase interval write A0h; its rising edge ends erase.
// - wait 6 us after each erase-verify write before reading.
// - after erase completes write reset command FFh.
// - start byte programming by writing 40h, a setup-only write.
// - program-verify command ends programming; it runs until then.
// - writes need output-enable high, chip-enable and write-enable low.
// - program-verify is C0h; its rising edge ends the program pulse.
package flash_erase_pkg;
  localparam int ADDR_W = 17;
  localparam logic [ADDR_W-1:0] ADDR_FIRST = 17'h00000;
  localparam logic [ADDR_W-1:0] ADDR_LAST = 17'h1FFFF;
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_ERASE_VERIFY = 8'hA0;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
  localparam logic [7:0] CMD_PROG_VERIFY = 8'hC0;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] DATA_ERASED = 8'hFF;
  localparam logic [7:0] DATA_ZERO = 8'h00;
  localparam logic [9:0] PULSE_LIMIT = 10'h3E8;
  localparam int CLK_MHZ = 40;
  localparam int ERASE_US = 10000;
  localparam int PROG_US = 10;
  localparam int RECOVER_US = 6;
  localparam int ERASE_CYC = ERASE_US * CLK_MHZ;
  localparam int PROG_CYC = PROG_US * CLK_MHZ;
  localparam int RECOVER_CYC = RECOVER_US * CLK_MHZ;
  localparam int STROBE_CYC = 4;
  localparam int CNT_W = 20;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h00, ST_SCAN_RD = 5'h01, ST_SCAN_CHK = 5'h02,
    ST_ZERO_SETUP = 5'h03, ST_ZERO_WR = 5'h04, ST_ZERO_WAIT = 5'h05,
    ST_ZERO_VER = 5'h06, ST_ZERO_REC = 5'h07, ST_ZERO_RD = 5'h08,
    ST_ER_SETUP = 5'h09, ST_ER_GO = 5'h0A, ST_ER_WAIT = 5'h0B,
    ST_EV_WR = 5'h0C, ST_EV_REC = 5'h0D, ST_EV_RD = 5'h0E,
    ST_EV_CHK = 5'h0F, ST_RESET_WR = 5'h10, ST_DONE = 5'h11,
    ST_FAIL = 5'h12, ST_PROG_SETUP = 5'h13, ST_ZERO_CHK = 5'h14
  } seq_state_t;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0, BUS_WRITE = 2'h1, BUS_READ = 2'h2
  } bus_op_t;
endpackage : flash_erase_pkg

// *** tb.sv ***
// self-checking testbench for the bulk erase host sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
  import flash_erase_pkg::*;
  logic sys_clk, rst_n, go;
  logic busy, erase_ok, erase_fail, ce_n, we_n, oe_n, dq_oe, program_supply;
  logic [9:0] pulses;
  // short array range keeps every scan and erase pass brief
  localparam logic [ADDR_W-1:0] SCAN_LAST = 17'h0000F;
  logic [ADDR_W-1:0] fail_addr, addr, exp_rd, rnd_addr;
  logic [7:0] dq_out, dev_dq, dq_bus, rnd_val;
  logic [ADDR_W+7:0] wq [$];
  int miscompares, n_checks, rd_cnt, rd_bad, cycles, seed;
  int n_weak, n_er, n_pv, n_ev, n_evw, n_bad, first_er, last_pv;
  assign dq_bus = dq_oe ? dq_out : dev_dq;
  flash_erase_host #(.ERASE_WAIT(50), .LAST_ADDR(SCAN_LAST)) dut (
    .sys_clk(sys_clk), .rst_n(rst_n),
    .go(go), .dq_in(dq_bus), .busy(busy), .erase_ok(erase_ok),
    .erase_fail(erase_fail), .pulses(pulses), .fail_addr(fail_addr),
    .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(addr), .dq_out(dq_out),
    .dq_oe(dq_oe), .program_supply(program_supply));
  flash_dev_model dev (.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(addr),
    .dq_in(dq_out), .program_supply(program_supply), .dq(dev_dq));
  ////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check
  task wrap_up;
    if (miscompares == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  task start_run;
    int i;
    wq.delete();
    rd_cnt = 0;
    rd_bad = 0;
    exp_rd = ADDR_FIRST;
    go = 1'b1;
    for (i = 0; i < 20 && busy !== 1'b1; i++) @(posedge sys_clk) #2;
    go = 1'b0;
  endtask : start_run
  ////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // three runs over the short range need well under this
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles > 60000) begin
      miscompares++;
      wrap_up();
    end
  end
  // bus monitors: strobe states, write log, scan order
  always @(negedge we_n) begin
    #1;
    check({oe_n, ce_n}, 2'b10);
  end
  always @(posedge we_n) begin
    if (!ce_n) wq.push_back({addr, dq_out});
  end
  always @(negedge oe_n) begin
    #1;
    if (!ce_n && rd_cnt <= int'(SCAN_LAST)) begin
      if (addr !== exp_rd) rd_bad++;
      exp_rd = addr + 1'b1;
      rd_cnt++;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    int i;
    seed = 10097;
    miscompares = 0;
    n_checks = 0;
    cycles = 0;
    go = 1'b0;
    rst_n = 1'b0;
    repeat (5) @(posedge sys_clk);
    #2 rst_n = 1'b1;
    // blank array: full scan, no erase, closing commands only
    start_run();
    while (busy === 1'b1) @(posedge sys_clk) #2;
    check(rd_cnt, 32'(SCAN_LAST) + 32'h1);
    check(rd_bad, 0);
    check({erase_ok, erase_fail}, 2'b10);
    check(pulses, 10'h000);
    check(wq.size(), 2);
    check(wq[0][7:0], CMD_PROG_SETUP);
    check(wq[1][7:0], CMD_RESET);
    // one random byte and byte 0 not erased: zero-fill must come first
    rnd_addr = ADDR_W'($random(seed)) & SCAN_LAST;
    rnd_val = 8'($random(seed));
    if (rnd_val == DATA_ERASED) rnd_val = DATA_ZERO;
    dev.mem[rnd_addr] = rnd_val;
    dev.mem[ADDR_FIRST] = 8'h5A;
    start_run();
    for (i = 0; i < 20000 && wq.size() < 3; i++) @(posedge sys_clk) #2;
    check(wq.size() >= 3, 1'b1);
    check(wq[0][7:0], CMD_PROG_SETUP);
    check(wq[1], {ADDR_FIRST, DATA_ZERO});
    check(wq[2][7:0], CMD_PROG_VERIFY);
    check(program_supply, 1'b1);
    repeat (20) @(posedge sys_clk);
    check(dev.mem[ADDR_FIRST], DATA_ZERO);
    // reset in mid-run returns pins to their idle levels
    #2 rst_n = 1'b0;
    repeat (3) @(posedge sys_clk);
    #2;
    check({ce_n, we_n, oe_n, dq_oe, busy}, 5'b11100);
    rst_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    check(busy, 1'b0);
    // full erase: a weak byte needs extra pulses, verify resumes there
    for (i = 0; i <= int'(SCAN_LAST); i++) dev.mem[i] = 8'($random(seed));
    dev.mem[ADDR_FIRST] = 8'h5A;
    dev.weak_addr = ADDR_W'($random(seed)) & SCAN_LAST;
    n_weak = 1 + ($random(seed) & 3);
    dev.weak_left = n_weak;
    start_run();
    while (busy === 1'b1) @(posedge sys_clk) #2;
    n_er = 0;
    n_pv = 0;
    n_ev = 0;
    n_evw = 0;
    n_bad = 0;
    first_er = -1;
    last_pv = -1;
    for (i = 0; i < wq.size(); i++) begin
      if (wq[i][7:0] == CMD_ERASE) begin
        n_er++;
        if (first_er < 0) first_er = i;
      end
      if (wq[i][7:0] == CMD_PROG_VERIFY) begin
        n_pv++;
        last_pv = i;
      end
      if (wq[i][7:0] == CMD_ERASE_VERIFY) begin
        if (n_ev == 0) check(wq[i][ADDR_W+7:8], ADDR_FIRST);
        n_ev++;
        if (wq[i][ADDR_W+7:8] == dev.weak_addr) n_evw++;
      end
    end
    for (i = 0; i <= int'(SCAN_LAST); i++) begin
      if (dev.mem[i] !== DATA_ERASED) n_bad++;
    end
    check(rd_cnt, 32'(SCAN_LAST) + 32'h1);
    check(rd_bad, 0);
    check({erase_ok, erase_fail}, 2'b10);
    check(pulses, 10'(n_weak));
    check(fail_addr, SCAN_LAST);
    check(n_pv, 32'(SCAN_LAST) + 32'h1);
    check(first_er > last_pv, 1'b1);
    check(n_er, 2 * (n_weak + 1));
    check(n_ev, 32'(SCAN_LAST) + 32'h1 + n_weak);
    check(n_evw, n_weak + 1);
    check(n_bad, 0);
    check(wq[wq.size() - 2][7:0], CMD_PROG_SETUP);
    check(wq[wq.size() - 1][7:0], CMD_RESET);
    check(program_supply, 1'b0);
    wrap_up();
  end
endmodule : tb
`default_nettype wire
